// ===== common/card_detect_defs.vh
// constants for the card presence and type detection block
`ifndef CARD_DETECT_DEFS_VH
`define CARD_DETECT_DEFS_VH

// ========================================================
// clock and timing
`define CLK_FREQ_HZ 40000000
`define DEBOUNCE_MS 50
`define OSC_FREQ_HZ 16000
`define SETTLE_TICKS 4

// ========================================================
// slot indices of the filtered detect inputs
`define SLOT_SD 0
`define SLOT_STICK 1
`define SLOT_SMARTMEDIA 2
`define SLOT_PICTURE 3
`define SLOT_CHIP 4
`define SLOT_COUNT 5

// ========================================================
// bit positions of the card class word
`define CLS_V5 0
`define CLS_V33 1
`define CLS_VX 2
`define CLS_VY 3
`define CLS_B16 4
`define CLS_CB 5
`define CLS_USB 6
`define CLS_CORE18 7
`define CLS_WIDTH 8
`define CLS_RESET 8'h00

`endif

// ===== verilog/detect_debounce.v
// insertion debounce filter for one active-low detect input
`timescale 1ns/100ps
module detect_debounce #(
    parameter COUNT = 2000000,
    parameter W = 21
) (
    input wire clk_sys,
    input wire nrst,
    input wire detect_n,
    output reg present_q
);
    reg sync1_q;
    reg sync2_q;
    reg [W-1:0] cnt_q;

    // ========================================================
    // pin synchroniser, the first stage is read by the second only
    always @(posedge clk_sys) begin
        if (!nrst) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= detect_n;
            sync2_q <= sync1_q;
        end
    end

    // ========================================================
    // low must stand for the whole interval; any high restarts it and
    // drops presence at once, so removal is never delayed
    always @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_q <= {W{1'b0}};
            present_q <= 1'b0;
        end else if (sync2_q) begin
            cnt_q <= {W{1'b0}};
            present_q <= 1'b0;
        end else if (!present_q) begin
            if (cnt_q == COUNT[W-1:0] - 1'b1) begin
                present_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule

// ===== verilog/card_insertion_detect.v
// card presence, card type interrogation and memory socket power states
`timescale 1ns/100ps
`include "card_detect_defs.vh"
module card_insertion_detect #(
    parameter DEBOUNCE_CYCLES = `DEBOUNCE_MS * (`CLK_FREQ_HZ / 1000),
    parameter DEB_W = 21,
    parameter OSC_DIV = `CLK_FREQ_HZ / `OSC_FREQ_HZ
) (
    input wire clk_sys,
    input wire nrst,
    input wire power_switch_type_select,
    input wire socket_vcc_on,
    input wire card_detect_one_in,
    output wire card_detect_one_out,
    output wire card_detect_one_oe_n,
    input wire card_detect_two_in,
    output wire card_detect_two_out,
    output wire card_detect_two_oe_n,
    input wire volt_sense_one_in,
    output wire volt_sense_one_out,
    output wire volt_sense_one_oe_n,
    input wire volt_sense_two_in,
    output wire volt_sense_two_out,
    output wire volt_sense_two_oe_n,
    input wire sd_socket_detect_n,
    input wire stick_socket_detect_n,
    input wire smartmedia_socket_detect_n,
    input wire picture_socket_detect_n,
    input wire chip_card_detect_n,
    input wire [3:0] media_power_req,
    input wire chip_power_req,
    output reg socket_card_present,
    output reg card_is_16bit,
    output reg card_is_cardbus,
    output reg usb_custom_card,
    output reg five_volt_card_flag,
    output reg low_volt_card_flag,
    output reg other_volt_card_flag,
    output wire interrogation_busy,
    output reg osc_tick,
    output wire [3:0] media_present,
    output wire [3:0] media_power_en,
    output wire chip_card_present,
    output wire chip_power_en
);
    // interrogation states
    localparam [2:0] IQ_EMPTY = 3'h0;
    localparam [2:0] IQ_SETTLE = 3'h1;
    localparam [2:0] IQ_RELEASED = 3'h2;
    localparam [2:0] IQ_PROBE_ONE = 3'h3;
    localparam [2:0] IQ_PROBE_TWO = 3'h4;
    localparam [2:0] IQ_DONE = 3'h5;
    // memory socket power states
    localparam [1:0] MS_EMPTY = 2'h0;
    localparam [1:0] MS_PRESENT_OFF = 2'h1;
    localparam [1:0] MS_POWERED = 2'h2;
    localparam [2:0] SETTLE_LAST = `SETTLE_TICKS - 1;
    // ========================================================
    // card class decode
    // levels: 1 = open (pulled up), 0 = grounded; sNM = detect N tied to sense M
    function [`CLS_WIDTH-1:0] classify;
        input cd1;
        input cd2;
        input vs1;
        input vs2;
        input s11;
        input s12;
        input s21;
        input s22;
        reg [`CLS_WIDTH-1:0] c;
        begin
            c = `CLS_RESET;
            if (!cd1 && !cd2) begin
                c[`CLS_B16] = 1'b1;
                case ({vs2, vs1})
                    2'b11: c[`CLS_V5] = 1'b1;
                    2'b10: begin
                        c[`CLS_V5] = 1'b1;
                        c[`CLS_V33] = 1'b1;
                    end
                    2'b00: begin
                        c[`CLS_V5] = 1'b1;
                        c[`CLS_V33] = 1'b1;
                        c[`CLS_VX] = 1'b1;
                    end
                    default: c[`CLS_VX] = 1'b1;
                endcase
            end else if (s11 && !cd2) begin
                if (vs2) begin
                    c[`CLS_CB] = 1'b1;
                    c[`CLS_V33] = 1'b1;
                end else begin
                    c[`CLS_USB] = 1'b1;
                end
            end else if (s12 && !cd2 && vs1) begin
                c[`CLS_CB] = 1'b1;
                c[`CLS_VX] = 1'b1;
                c[`CLS_VY] = 1'b1;
            end else if (s22 && !cd1) begin
                c[`CLS_CB] = 1'b1;
                if (vs1) begin
                    c[`CLS_CORE18] = 1'b1;
                end else begin
                    c[`CLS_V33] = 1'b1;
                    c[`CLS_VX] = 1'b1;
                end
            end else if (s21 && !cd1) begin
                c[`CLS_CB] = 1'b1;
                c[`CLS_VY] = 1'b1;
                if (!vs2) begin
                    c[`CLS_V33] = 1'b1;
                    c[`CLS_VX] = 1'b1;
                end
            end
            // reserved and unsupported custom patterns stay all zero
            classify = c;
        end
    endfunction
    // ========================================================
    // free-running slow tick, independent of any host bus clock
    reg [11:0] osc_cnt_q;
    always @(posedge clk_sys) begin
        if (!nrst) begin
            osc_cnt_q <= 12'h000;
            osc_tick <= 1'b0;
        end else if (osc_cnt_q == OSC_DIV[11:0] - 12'h001) begin
            osc_cnt_q <= 12'h000;
            osc_tick <= 1'b1;
        end else begin
            osc_cnt_q <= osc_cnt_q + 12'h001;
            osc_tick <= 1'b0;
        end
    end
    // ========================================================
    // synchronisers for the four socket pins
    reg [3:0] pin_s1_q;
    reg [3:0] pin_s2_q;
    always @(posedge clk_sys) begin
        if (!nrst) begin
            pin_s1_q <= 4'hf;
            pin_s2_q <= 4'hf;
        end else begin
            pin_s1_q <= {volt_sense_two_in, volt_sense_one_in,
                         card_detect_two_in, card_detect_one_in};
            pin_s2_q <= pin_s1_q;
        end
    end
    wire cd1_s = pin_s2_q[0];
    wire cd2_s = pin_s2_q[1];
    wire vs1_s = pin_s2_q[2];
    wire vs2_s = pin_s2_q[3];
    // a card always grounds at least one detect pin
    wire socket_vacant = cd1_s && cd2_s;
    // ========================================================
    // interrogation sequencer
    // each step waits a full slow tick so the pulled-up pins settle
    reg [2:0] iq_q;
    reg [2:0] settle_q;
    reg [3:0] rel_q;
    reg [1:0] strap_one_q;
    reg drive_cd1_q;
    reg drive_cd2_q;
    reg [`CLS_WIDTH-1:0] class_q;
    always @(posedge clk_sys) begin
        if (!nrst) begin
            iq_q <= IQ_EMPTY;
            settle_q <= 3'h0;
            rel_q <= 4'hf;
            strap_one_q <= 2'h0;
            drive_cd1_q <= 1'b0;
            drive_cd2_q <= 1'b0;
            class_q <= `CLS_RESET;
        end else begin
            case (iq_q)
                IQ_EMPTY: begin
                    class_q <= `CLS_RESET;
                    settle_q <= 3'h0;
                    // only a cold socket is interrogated
                    if (!socket_vacant && !socket_vcc_on) begin
                        iq_q <= IQ_SETTLE;
                    end
                end
                IQ_SETTLE: begin
                    if (socket_vacant) begin
                        iq_q <= IQ_EMPTY;
                    end else if (osc_tick) begin
                        if (settle_q == SETTLE_LAST) begin
                            iq_q <= IQ_RELEASED;
                        end else begin
                            settle_q <= settle_q + 3'h1;
                        end
                    end
                end
                IQ_RELEASED: begin
                    if (socket_vacant) begin
                        iq_q <= IQ_EMPTY;
                    end else if (osc_tick) begin
                        rel_q <= pin_s2_q;
                        drive_cd1_q <= 1'b1;
                        iq_q <= IQ_PROBE_ONE;
                    end
                end
                IQ_PROBE_ONE: begin
                    // a sense pin open when released but low now is tied to detect one
                    if (osc_tick) begin
                        strap_one_q <= {rel_q[3] & ~vs2_s, rel_q[2] & ~vs1_s};
                        drive_cd1_q <= 1'b0;
                        drive_cd2_q <= 1'b1;
                        iq_q <= IQ_PROBE_TWO;
                    end
                end
                IQ_PROBE_TWO: begin
                    if (osc_tick) begin
                        drive_cd2_q <= 1'b0;
                        class_q <= classify(rel_q[0], rel_q[1], rel_q[2], rel_q[3],
                                            strap_one_q[0], strap_one_q[1],
                                            rel_q[2] & ~vs1_s, rel_q[3] & ~vs2_s);
                        iq_q <= IQ_DONE;
                    end
                end
                IQ_DONE: begin
                    if (socket_vacant) begin
                        iq_q <= IQ_EMPTY;
                    end
                end
                default: begin
                    iq_q <= IQ_EMPTY;
                    drive_cd1_q <= 1'b0;
                    drive_cd2_q <= 1'b0;
                end
            endcase
        end
    end
    // open-drain probe: pins only ever pulled low, sense pins never driven
    assign card_detect_one_out = 1'b0;
    assign card_detect_two_out = 1'b0;
    assign volt_sense_one_out = 1'b0;
    assign volt_sense_two_out = 1'b0;
    assign card_detect_one_oe_n = ~drive_cd1_q;
    assign card_detect_two_oe_n = ~drive_cd2_q;
    assign volt_sense_one_oe_n = 1'b1;
    assign volt_sense_two_oe_n = 1'b1;
    assign interrogation_busy = (iq_q != IQ_EMPTY) && (iq_q != IQ_DONE);
    // ========================================================
    // present-state flags; switch select applies live, so a later flip re-routes the report
    wire class_valid = |class_q;
    always @(posedge clk_sys) begin
        if (!nrst) begin
            socket_card_present <= 1'b0;
            card_is_16bit <= 1'b0;
            card_is_cardbus <= 1'b0;
            usb_custom_card <= 1'b0;
            five_volt_card_flag <= 1'b0;
            low_volt_card_flag <= 1'b0;
            other_volt_card_flag <= 1'b0;
        end else begin
            socket_card_present <= class_valid && (iq_q == IQ_DONE);
            card_is_16bit <= class_q[`CLS_B16];
            card_is_cardbus <= class_q[`CLS_CB];
            usb_custom_card <= class_q[`CLS_USB];
            five_volt_card_flag <= class_q[`CLS_V5];
            low_volt_card_flag <= class_q[`CLS_V33] |
                (class_q[`CLS_CORE18] & ~power_switch_type_select);
            other_volt_card_flag <= class_q[`CLS_VX] | class_q[`CLS_VY] |
                (class_q[`CLS_CORE18] & power_switch_type_select);
        end
    end
    // ========================================================
    // memory and chip card sockets: debounce then three-state power control
    wire [`SLOT_COUNT-1:0] detect_n = {chip_card_detect_n, picture_socket_detect_n,
                                       smartmedia_socket_detect_n, stick_socket_detect_n,
                                       sd_socket_detect_n};
    wire [`SLOT_COUNT-1:0] power_req = {chip_power_req, media_power_req};
    wire [`SLOT_COUNT-1:0] filt_present;
    wire [`SLOT_COUNT-1:0] slot_present;
    wire [`SLOT_COUNT-1:0] slot_power;
    genvar i;
    generate
        for (i = 0; i < `SLOT_COUNT; i = i + 1) begin : g_slot
            reg [1:0] ms_q;
            // insertion filtered, removal immediate
            detect_debounce #(
                .COUNT(DEBOUNCE_CYCLES),
                .W(DEB_W)
            ) u_deb (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .detect_n(detect_n[i]),
                .present_q(filt_present[i])
            );
            // power is granted only to a filtered present card
            always @(posedge clk_sys) begin
                if (!nrst) begin
                    ms_q <= MS_EMPTY;
                end else if (!filt_present[i]) begin
                    ms_q <= MS_EMPTY;
                end else begin
                    case (ms_q)
                        MS_EMPTY: ms_q <= MS_PRESENT_OFF;
                        MS_PRESENT_OFF: begin
                            if (power_req[i]) begin
                                ms_q <= MS_POWERED;
                            end
                        end
                        MS_POWERED: begin
                            if (!power_req[i]) begin
                                ms_q <= MS_PRESENT_OFF;
                            end
                        end
                        default: ms_q <= MS_EMPTY;
                    endcase
                end
            end
            assign slot_present[i] = (ms_q != MS_EMPTY);
            assign slot_power[i] = (ms_q == MS_POWERED);
        end
    endgenerate
    assign media_present = slot_present[3:0];
    assign media_power_en = slot_power[3:0];
    assign chip_card_present = slot_present[`SLOT_CHIP];
    assign chip_power_en = slot_power[`SLOT_CHIP];
endmodule

// ===== tb/card_insertion_detect_props.sv
// assertions on the ports of the card detection block
`timescale 1ns/100ps
module card_insertion_detect_props #(
    parameter DEBOUNCE_CYCLES = 20,
    parameter OSC_DIV = 8
) (
    input wire clk_sys,
    input wire nrst,
    input wire socket_vcc_on,
    input wire card_detect_one_in,
    input wire card_detect_two_in,
    input wire card_detect_one_out,
    input wire card_detect_two_out,
    input wire volt_sense_one_out,
    input wire volt_sense_two_out,
    input wire card_detect_one_oe_n,
    input wire card_detect_two_oe_n,
    input wire volt_sense_one_oe_n,
    input wire volt_sense_two_oe_n,
    input wire sd_socket_detect_n,
    input wire chip_card_detect_n,
    input wire [3:0] media_power_req,
    input wire chip_power_req,
    input wire socket_card_present,
    input wire interrogation_busy,
    input wire osc_tick,
    input wire [3:0] media_present,
    input wire [3:0] media_power_en,
    input wire chip_card_present,
    input wire chip_power_en
);
    int sd_low_q;
    int chip_low_q;
    int gap_q;
    logic seen_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ====
    // helper counters: low run of the sd and chip detect pins, clocks between oscillator ticks
    always @(posedge clk_sys) begin
        if (!nrst) begin
            sd_low_q <= 0;
            chip_low_q <= 0;
            gap_q <= 0;
            seen_q <= 1'b0;
        end else begin
            sd_low_q <= sd_socket_detect_n ? 0 : sd_low_q + 1;
            chip_low_q <= chip_card_detect_n ? 0 : chip_low_q + 1;
            gap_q <= osc_tick ? 1 : gap_q + 1;
            seen_q <= seen_q | osc_tick;
        end
    end
    // ====
    // properties
    property p_open_drain;
        !card_detect_one_out && !card_detect_two_out && !volt_sense_one_out &&
            !volt_sense_two_out && volt_sense_one_oe_n && volt_sense_two_oe_n;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    property p_one_probe;
        (!card_detect_one_oe_n || !card_detect_two_oe_n) |->
            (card_detect_one_oe_n || card_detect_two_oe_n) && interrogation_busy;
    endproperty
    a_one_probe: assert property (p_one_probe) else $error("bad probe");
    property p_cold_only;
        socket_vcc_on && !interrogation_busy |=> !interrogation_busy;
    endproperty
    a_cold_only: assert property (p_cold_only) else $error("warm probe");
    property p_clear;
        (card_detect_one_in && card_detect_two_in && !interrogation_busy)[*8]
            |-> !socket_card_present;
    endproperty
    a_clear: assert property (p_clear) else $error("stale card");
    property p_sd_deb;
        $rose(media_present[0]) |-> sd_low_q >= DEBOUNCE_CYCLES;
    endproperty
    a_sd_deb: assert property (p_sd_deb) else $error("early media present");
    property p_chip_deb;
        $rose(chip_card_present) |-> chip_low_q >= DEBOUNCE_CYCLES;
    endproperty
    a_chip_deb: assert property (p_chip_deb) else $error("early chip present");
    property p_sd_rm;
        sd_socket_detect_n[*6] |-> !media_present[0] && !media_power_en[0];
    endproperty
    a_sd_rm: assert property (p_sd_rm) else $error("slow media removal");
    property p_chip_rm;
        chip_card_detect_n[*6] |-> !chip_card_present && !chip_power_en;
    endproperty
    a_chip_rm: assert property (p_chip_rm) else $error("slow chip removal");
    property p_pwr_card;
        (media_power_en & ~media_present) == 4'h0 && (!chip_power_en || chip_card_present);
    endproperty
    a_pwr_card: assert property (p_pwr_card) else $error("power without card");
    property p_pwr_on;
        (media_present[0] && media_power_req[0]) ##1 media_present[0] |-> media_power_en[0];
    endproperty
    a_pwr_on: assert property (p_pwr_on) else $error("power not on");
    property p_pwr_off;
        !chip_power_req |=> !chip_power_en;
    endproperty
    a_pwr_off: assert property (p_pwr_off) else $error("power not off");
    property p_osc;
        osc_tick && seen_q |-> gap_q == OSC_DIV;
    endproperty
    a_osc: assert property (p_osc) else $error("tick period wrong");
    c_probe: cover property ($fell(interrogation_busy));
    c_media: cover property ($rose(media_power_en[0]));
    c_chip: cover property ($rose(chip_power_en));
endmodule

bind card_insertion_detect card_insertion_detect_props #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .OSC_DIV(OSC_DIV)) props_i (
    .clk_sys, .nrst, .socket_vcc_on, .card_detect_one_in, .card_detect_two_in,
    .card_detect_one_out, .card_detect_two_out, .volt_sense_one_out, .volt_sense_two_out,
    .card_detect_one_oe_n, .card_detect_two_oe_n,
    .volt_sense_one_oe_n, .volt_sense_two_oe_n, .sd_socket_detect_n, .chip_card_detect_n,
    .media_power_req, .chip_power_req, .socket_card_present, .interrogation_busy,
    .osc_tick, .media_present, .media_power_en, .chip_card_present, .chip_power_en);

// ===== tb/card_model.sv
// behavioural card in the pc card socket: grounds and straps detect and sense pins
`timescale 1ns/100ps
module card_model (
    input wire inserted,
    input wire [3:0] grounded,
    input wire [2:0] strap,
    input wire cd1_oe_n,
    input wire cd2_oe_n,
    output wire cd1,
    output wire cd2,
    output wire vs1,
    output wire vs2
);
    wire r1, r2, s1, s2, a1, a2, a3, a4;
    // own levels: pulled up, low where the card grounds or the device pulls
    assign r2 = ~(inserted & grounded[3]) & cd2_oe_n;
    assign r1 = ~(inserted & grounded[2]) & cd1_oe_n;
    assign s2 = ~(inserted & grounded[1]);
    assign s1 = ~(inserted & grounded[0]);
    // a strap joins a detect and a sense pin into one wired-and net
    assign a1 = inserted && strap == 3'h1;
    assign a2 = inserted && strap == 3'h2;
    assign a3 = inserted && strap == 3'h3;
    assign a4 = inserted && strap == 3'h4;
    assign cd1 = r1 & (~a1 | s1) & (~a2 | s2);
    assign cd2 = r2 & (~a3 | s1) & (~a4 | s2);
    assign vs1 = s1 & (~a1 | r1) & (~a3 | r2);
    assign vs2 = s2 & (~a2 | r1) & (~a4 | r2);
endmodule

// ===== tb/card_insertion_detect_tb_top.sv
// self-checking bench for the card presence and type detection block
`timescale 1ns/100ps
module card_insertion_detect_tb_top;
    localparam int DEB = 20;
    localparam int OSC = 8;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic sel = 1'b0;
    logic vcc = 1'b0;
    logic ins = 1'b0;
    logic [3:0] gnd = 4'h0;
    logic [2:0] strap = 3'h0;
    logic [4:0] det_n = 5'h1f;
    logic [4:0] preq = 5'h0;
    wire cd1, cd2, vs1, vs2, oe1, oe2, busy;
    wire [6:0] flags;
    wire [4:0] pres, pen;
    int err_count = 0;
    int n_compared = 0;
    // rows: grounded {cd2,cd1,vs2,vs1}, strap, select, expected flags
    logic [14:0] rows [13] = '{
        {4'hc, 3'h0, 1'b0, 7'h64}, {4'hd, 3'h0, 1'b0, 7'h66}, {4'hf, 3'h0, 1'b0, 7'h67},
        {4'he, 3'h0, 1'b0, 7'h61}, {4'h8, 3'h1, 1'b0, 7'h52}, {4'ha, 3'h1, 1'b0, 7'h48},
        {4'h8, 3'h2, 1'b0, 7'h51}, {4'h9, 3'h2, 1'b0, 7'h00}, {4'h5, 3'h4, 1'b0, 7'h53},
        {4'h4, 3'h4, 1'b0, 7'h52}, {4'h4, 3'h4, 1'b1, 7'h51}, {4'h6, 3'h3, 1'b0, 7'h53},
        {4'h4, 3'h3, 1'b0, 7'h51}};

    always #12.5 clk_sys = ~clk_sys;

    card_model card_i (.inserted(ins), .grounded(gnd), .strap(strap), .cd1_oe_n(oe1),
        .cd2_oe_n(oe2), .cd1(cd1), .cd2(cd2), .vs1(vs1), .vs2(vs2));

    card_insertion_detect #(.DEBOUNCE_CYCLES(DEB), .OSC_DIV(OSC)) DUT (
        .clk_sys(clk_sys), .nrst(nrst), .power_switch_type_select(sel), .socket_vcc_on(vcc),
        .card_detect_one_in(cd1), .card_detect_one_out(), .card_detect_one_oe_n(oe1),
        .card_detect_two_in(cd2), .card_detect_two_out(), .card_detect_two_oe_n(oe2),
        .volt_sense_one_in(vs1), .volt_sense_one_out(), .volt_sense_one_oe_n(),
        .volt_sense_two_in(vs2), .volt_sense_two_out(), .volt_sense_two_oe_n(),
        .sd_socket_detect_n(det_n[0]), .stick_socket_detect_n(det_n[1]),
        .smartmedia_socket_detect_n(det_n[2]), .picture_socket_detect_n(det_n[3]),
        .chip_card_detect_n(det_n[4]), .media_power_req(preq[3:0]), .chip_power_req(preq[4]),
        .socket_card_present(flags[6]), .card_is_16bit(flags[5]), .card_is_cardbus(flags[4]),
        .usb_custom_card(flags[3]), .five_volt_card_flag(flags[2]),
        .low_volt_card_flag(flags[1]), .other_volt_card_flag(flags[0]),
        .interrogation_busy(busy), .osc_tick(), .media_present(pres[3:0]),
        .media_power_en(pen[3:0]), .chip_card_present(pres[4]), .chip_power_en(pen[4]));

    // ====
    // shared tasks
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // bounded wait on the busy level; running out ends the run
    task automatic wait_busy(input logic val, input int bound);
        int n;
        n = 0;
        while (busy !== val && n < bound) begin
            cyc(1);
            n++;
        end
        if (busy !== val) begin
            err_count++;
            test_done();
        end
    endtask
    task automatic classify(input logic [14:0] r);
        cyc(1);
        gnd = r[14:11];
        strap = r[10:8];
        sel = r[7];
        ins = 1'b1;
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 20 * OSC);
        cyc(2);
        chk({1'b0, flags}, {1'b0, r[6:0]});
    endtask
    task automatic eject;
        ins = 1'b0;
        cyc(12);
        chk({1'b0, flags}, 8'h00);
    endtask
    // one memory or chip socket: refused power, glitchy insertion, power, removal
    task automatic socket(input int i);
        int n;
        preq[i] = 1'b1;
        cyc(4);
        chk({7'h0, pen[i]}, 8'h00);
        preq[i] = 1'b0;
        det_n[i] = 1'b0;
        cyc(10);
        det_n[i] = 1'b1;
        cyc(1);
        det_n[i] = 1'b0;
        n = 0;
        while (pres[i] !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        chk({7'h0, n >= DEB && n <= DEB + 6}, 8'h01);
        preq[i] = 1'b1;
        cyc(2);
        chk({7'h0, pen[i]}, 8'h01);
        preq[i] = 1'b0;
        cyc(2);
        chk({6'h0, pres[i], pen[i]}, 8'h02);
        preq[i] = 1'b1;
        cyc(2);
        det_n[i] = 1'b1;
        cyc(5);
        chk({6'h0, pres[i], pen[i]}, 8'h00);
        preq[i] = 1'b0;
    endtask

    // ====
    // main sequence
    initial begin
        cyc(5);
        chk({busy, flags}, 8'h00);
        chk({6'h0, oe1, oe2}, 8'h03);
        chk({3'h0, pres | pen}, 8'h00);
        nrst = 1'b1;
        for (int k = 0; k < 13; k++) begin
            classify(rows[k]);
            eject();
        end
        // core card seated, then the switch type flips: report follows live
        classify(rows[9]);
        sel = 1'b1;
        cyc(3);
        chk({1'b0, flags}, 8'h51);
        eject();
        // powered socket: insertion waits until the socket goes cold
        vcc = 1'b1;
        gnd = 4'hc;
        strap = 3'h0;
        ins = 1'b1;
        cyc(100);
        chk({busy, flags}, 8'h00);
        vcc = 1'b0;
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 20 * OSC);
        cyc(2);
        chk({1'b0, flags}, 8'h64);
        for (int i = 0; i < 5; i++) begin
            socket(i);
        end
        // reset in mid-run with a card seated
        nrst = 1'b0;
        cyc(2);
        chk({busy, flags}, 8'h00);
        chk({3'h0, pres | pen}, 8'h00);
        chk({6'h0, oe1, oe2}, 8'h03);
        cyc(3);
        nrst = 1'b1;
        // the seated card is interrogated afresh once reset lets go
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 20 * OSC);
        cyc(2);
        chk({1'b0, flags}, 8'h64);
        test_done();
    end
endmodule
